//--- logic/lds_defs.svh
`ifndef LDS_DEFS_SVH
`define LDS_DEFS_SVH

// ---------------------------------------------------------------
// Link figures
// ---------------------------------------------------------------
`define LDS_LANE_MBPS 600
`define LDS_FACTOR 8
`define LDS_REF_MHZ (`LDS_LANE_MBPS / `LDS_FACTOR)
`define LDS_FAST_MHZ (`LDS_LANE_MBPS / 2)
`define LDS_LANES 4
// Phase shifts in tenths of a degree, magnitude (applied as negative)
`define LDS_FAST_SHIFT_DDEG 900
`define LDS_WORD_SHIFT_DDEG (1800 / `LDS_FACTOR)
// Word alignment offsets in bit positions toward the MSB
`define LDS_RX_SHIFT 2
`define LDS_TX_SHIFT 3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LDS_CLK_PERIOD_NS 4
`define LDS_PLL_RST_NS 40
`define LDS_PLL_RST_CYC ((`LDS_PLL_RST_NS + `LDS_CLK_PERIOD_NS - 1) / `LDS_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LDS_OFS_CTRL 8'h00
`define LDS_OFS_STAT 8'h04
`define LDS_OFS_ISTAT 8'h08
`define LDS_OFS_IMASK 8'h0C
`define LDS_OFS_CLKCFG 8'h10
`define LDS_OFS_TX0 8'h20
`define LDS_OFS_RX0 8'h30

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define LDS_CTRL_EN 0
`define LDS_CTRL_PLLRST 1
`define LDS_CTRL_AUTORST 2
`define LDS_CTRL_SRCSYNC 3
`define LDS_CTRL_FWDSPARE 4
`define LDS_CTRL_RST 8'h0C
`define LDS_STAT_LOCK 0
`define LDS_STAT_RUN 1
`define LDS_STAT_PLLRST 2
`define LDS_IRQ_LOSTLOCK 0
`define LDS_IRQ_LOCKED 1
`define LDS_IRQ_RXWORD 2
`define LDS_IRQ_W 3
`define LDS_TX_RST 8'h00

`endif

//--- logic/lds_pkg.sv
package lds_pkg;

   // Shared-PLL supervision states, Gray along reset, wait, run
   typedef enum logic [1:0] {
      LDS_PLL_RESET = 2'b00,
      LDS_PLL_WAIT = 2'b01,
      LDS_PLL_RUN = 2'b11
   } lds_pll_st_t;

   typedef logic [7:0] lds_word_t;

endpackage

//--- logic/lds_lane.sv
`timescale 1ns/10ps
`include "lds_defs.svh"

// One serial lane: two bits per clock in each direction, one per edge
module lds_lane
   import lds_pkg::*;
#(
   parameter int FACTOR = `LDS_FACTOR
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Word timing
   input wire logic run_i,
   input wire logic last_i,
   input wire logic first_i,
   // Serial side
   input wire logic [1:0] rx_pair_i,
   output logic [1:0] tx_pair_o,
   // Parallel side
   input wire logic [FACTOR-1:0] tx_word_i,
   output logic [FACTOR-1:0] rx_word_o,
   output logic rx_done_o
);

   logic [FACTOR-1:0] rx_sr_r, rx_sr_nxt;
   logic [FACTOR-1:0] rx_word_r, rx_word_nxt;
   logic rx_done_r, rx_done_nxt;
   logic [FACTOR-1:0] tx_sr_r, tx_sr_nxt;
   logic [1:0] tx_pair_r, tx_pair_nxt;
   logic [FACTOR-1:0] full_w;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      // Rising-edge bit is the earlier one of the pair
      full_w = {rx_sr_r[FACTOR-3:0], rx_pair_i};
      rx_sr_nxt = rx_sr_r;
      rx_word_nxt = rx_word_r;
      rx_done_nxt = 1'b0;
      tx_sr_nxt = tx_sr_r;
      tx_pair_nxt = tx_pair_r;
      if (run_i) begin
         rx_sr_nxt = full_w;
         if (last_i) begin
            // Word lands two bits up against the far side boundary
            rx_word_nxt = {full_w[FACTOR-1-`LDS_RX_SHIFT:0],
                           full_w[FACTOR-1:FACTOR-`LDS_RX_SHIFT]};
            rx_done_nxt = 1'b1;
         end
         if (first_i) begin
            // Launch rotated so data trails the forwarded clock
            tx_sr_nxt = {tx_word_i[FACTOR-1-`LDS_TX_SHIFT:0],
                         tx_word_i[FACTOR-1:FACTOR-`LDS_TX_SHIFT]};
         end else begin
            tx_sr_nxt = {tx_sr_r[FACTOR-3:0], 2'b00};
         end
         tx_pair_nxt = first_i ? tx_sr_nxt[FACTOR-1:FACTOR-2] : tx_sr_r[FACTOR-3:FACTOR-4];
      end else begin
         tx_pair_nxt = 2'b00;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_sr_r <= '0;
         rx_word_r <= '0;
         rx_done_r <= 1'b0;
         tx_sr_r <= '0;
         tx_pair_r <= 2'b00;
      end else if (ce_i) begin
         rx_sr_r <= rx_sr_nxt;
         rx_word_r <= rx_word_nxt;
         rx_done_r <= rx_done_nxt;
         tx_sr_r <= tx_sr_nxt;
         tx_pair_r <= tx_pair_nxt;
      end
   end

   assign rx_word_o = rx_word_r;
   assign rx_done_o = rx_done_r;
   assign tx_pair_o = tx_pair_r;

endmodule // lds_lane

//--- logic/lds_top.sv
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "lds_defs.svh"

// Overview of operation
// - Each lane runs at 600 Mbps against a 75 MHz reference, the bit rate over factor eight.
// - Lane capture and launch use both edges, so the fast clock is half the bit rate.
// - The word-rate clock is the bit rate over the factor, phase-aligned to the fast clock.
// - The compensated fast PLL output is set to 300 MHz.
// - The fast clock is shifted by minus ninety degrees to centre dual-edge capture.
// - The word clock is shifted by minus 180 degrees over the factor, minus 22.5 degrees.
// - The shared PLL has an asynchronous reset input and a lock output toward the logic.
// - Receiver and transmitter share one PLL, and a forwarded word clock is centred on data.
// - Each received word appears two bit positions toward the MSB.
// - Transmitted data appears three bit positions toward the MSB against the word clock.
// - A spare PLL output may be forwarded in place of the word clock.
// - Source-synchronous compensation is preferred, normal compensation is allowed.
// - There are four independent lanes each way, each of factor eight.
module lds_top
   import lds_pkg::*;
#(
   parameter int LANES = `LDS_LANES,
   parameter int FACTOR = `LDS_FACTOR
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Shared PLL control
   input wire logic pll_locked_i,
   input wire logic spare_pll_output_i,
   output logic pll_areset_o,
   output logic pll_srcsync_o,
   // Serial lanes, bit 1 of a pair on the rising edge
   input wire logic [2*LANES-1:0] rx_ser_i,
   output logic [2*LANES-1:0] tx_ser_o,
   output logic fwd_clk_o,
   // Core parallel side
   output logic [LANES*FACTOR-1:0] rx_par_o,
   output logic rx_valid_o,
   // Interrupt
   output logic irq_o
);

   localparam int CNT_W = $clog2(`LDS_PLL_RST_CYC + 1);
   localparam logic [CNT_W-1:0] RST_CYC = CNT_W'(`LDS_PLL_RST_CYC);
   localparam int PH_W = $clog2(FACTOR / 2);
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(FACTOR / 2 - 1);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [`LDS_IRQ_W-1:0] istat_r, istat_nxt;
   logic [`LDS_IRQ_W-1:0] imask_r, imask_nxt;
   logic [FACTOR-1:0] tx_word_r [LANES];
   logic [FACTOR-1:0] tx_word_nxt [LANES];
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic irq_r, irq_nxt;
   lds_pll_st_t st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic areset_r, areset_nxt;
   logic lock_r, lock_nxt;
   logic [PH_W-1:0] ph_r, ph_nxt;
   logic fwd_r, fwd_nxt;
   logic valid_r, valid_nxt;
   logic srcsync_r;
   logic [LANES*FACTOR-1:0] par_r, par_nxt;
   logic [LANES-1:0] done_w;
   logic [FACTOR-1:0] rxw_w [LANES];
   logic [2*LANES-1:0] txp_w;
   logic run_w, first_w, last_w, wr_w, rd_w, lost_w, gained_w;
   logic [7:0] idx_w;

   assign run_w = (st_r == LDS_PLL_RUN) && ctrl_r[`LDS_CTRL_EN];
   assign first_w = (ph_r == '0);
   assign last_w = (ph_r == PH_LAST);
   assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
   assign rd_w = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
   assign lost_w = lock_r && !pll_locked_i;
   assign gained_w = !lock_r && pll_locked_i && (st_r == LDS_PLL_WAIT);
   assign idx_w = {6'h00, wb_adr_i[3:2]};

   // ---------------------------------------------------------------
   // Lanes
   // ---------------------------------------------------------------
   // Four identical lanes sharing one word phase
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      lds_lane #(.FACTOR(FACTOR)) u_lane (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .run_i(run_w),
         .last_i(last_w),
         .first_i(first_w),
         .rx_pair_i(rx_ser_i[2*g+1:2*g]),
         .tx_pair_o(txp_w[2*g+1:2*g]),
         .tx_word_i(tx_word_r[g]),
         .rx_word_o(rxw_w[g]),
         .rx_done_o(done_w[g])
      );
   end

   // ---------------------------------------------------------------
   // PLL supervision and word timing
   // ---------------------------------------------------------------
   // Lost lock restarts the PLL so its output phases line up again
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      areset_nxt = 1'b0;
      lock_nxt = pll_locked_i;
      ph_nxt = ph_r;
      fwd_nxt = 1'b0;
      case (st_r)
         LDS_PLL_RESET: begin
            areset_nxt = 1'b1;
            if (cnt_r >= RST_CYC - 1'b1) begin
               st_nxt = LDS_PLL_WAIT;
               cnt_nxt = '0;
               areset_nxt = 1'b0;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         LDS_PLL_WAIT: begin
            if (pll_locked_i) begin
               st_nxt = LDS_PLL_RUN;
            end
         end
         LDS_PLL_RUN: begin
            if (!pll_locked_i && ctrl_r[`LDS_CTRL_AUTORST]) begin
               st_nxt = LDS_PLL_RESET;
               cnt_nxt = '0;
            end else if (!pll_locked_i) begin
               st_nxt = LDS_PLL_WAIT;
            end
         end
         default: begin
            st_nxt = LDS_PLL_RESET;
            cnt_nxt = '0;
         end
      endcase
      // Software may force a reset at any time
      if (ctrl_r[`LDS_CTRL_PLLRST]) begin
         st_nxt = LDS_PLL_RESET;
         cnt_nxt = '0;
         areset_nxt = 1'b1;
      end
      // Word phase counts pairs, one word per FACTOR/2 clocks
      if (run_w) begin
         ph_nxt = last_w ? '0 : ph_r + 1'b1;
      end else begin
         ph_nxt = '0;
      end
      // Word clock high over the first pairs on the pins: centred on data.
      // Launch pairs trail the phase count by one clock, hence the minus one.
      if (ctrl_r[`LDS_CTRL_FWDSPARE]) begin
         fwd_nxt = spare_pll_output_i;
      end else if (run_w) begin
         fwd_nxt = (PH_W'(ph_nxt - 1'b1) < PH_W'(FACTOR / 4));
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= LDS_PLL_RESET;
         cnt_r <= '0;
         areset_r <= 1'b1;
         lock_r <= 1'b0;
         ph_r <= '0;
         fwd_r <= 1'b0;
      end else if (ce_i) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         areset_r <= areset_nxt;
         lock_r <= lock_nxt;
         ph_r <= ph_nxt;
         fwd_r <= fwd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Received words to the core
   // ---------------------------------------------------------------
   always_comb begin
      par_nxt = par_r;
      valid_nxt = done_w[0];
      for (int i = 0; i < LANES; i++) begin
         if (done_w[i]) begin
            par_nxt[i*FACTOR +: FACTOR] = rxw_w[i];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         par_r <= '0;
         valid_r <= 1'b0;
      end else if (ce_i) begin
         par_r <= par_nxt;
         valid_r <= valid_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Register file and interrupt
   // ---------------------------------------------------------------
   // Hardware set beats a same-cycle write-one clear
   always_comb begin
      ctrl_nxt = ctrl_r;
      imask_nxt = imask_r;
      istat_nxt = istat_r;
      for (int i = 0; i < LANES; i++) begin
         tx_word_nxt[i] = tx_word_r[i];
      end
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt = 32'h0000_0000;
      if (wr_w) begin
         case (wb_adr_i)
            `LDS_OFS_CTRL: ctrl_nxt = wb_dat_i[7:0];
            `LDS_OFS_ISTAT: istat_nxt = istat_r & ~wb_dat_i[`LDS_IRQ_W-1:0];
            `LDS_OFS_IMASK: imask_nxt = wb_dat_i[`LDS_IRQ_W-1:0];
            default: begin
               if (wb_adr_i[7:4] == `LDS_OFS_TX0 >> 4) begin
                  tx_word_nxt[idx_w[1:0]] = wb_dat_i[FACTOR-1:0];
               end
            end
         endcase
      end
      if (rd_w) begin
         case (wb_adr_i)
            `LDS_OFS_CTRL: dat_nxt = {24'h000000, ctrl_r};
            `LDS_OFS_STAT: dat_nxt = {29'h00000000, areset_r, st_r == LDS_PLL_RUN, lock_r};
            `LDS_OFS_ISTAT: dat_nxt = {29'h00000000, istat_r};
            `LDS_OFS_IMASK: dat_nxt = {29'h00000000, imask_r};
            // Clock plan: fast MHz, fast shift, word shift
            `LDS_OFS_CLKCFG: dat_nxt = {7'h00, 9'(`LDS_FAST_MHZ),
                                        8'(`LDS_FAST_SHIFT_DDEG / 10),
                                        8'(`LDS_WORD_SHIFT_DDEG)};
            default: begin
               if (wb_adr_i[7:4] == `LDS_OFS_TX0 >> 4) begin
                  dat_nxt = {24'h000000, tx_word_r[idx_w[1:0]]};
               end else if (wb_adr_i[7:4] == `LDS_OFS_RX0 >> 4) begin
                  dat_nxt = {24'h000000, par_r[idx_w[1:0]*FACTOR +: FACTOR]};
               end
            end
         endcase
      end
      if (lost_w) begin
         istat_nxt[`LDS_IRQ_LOSTLOCK] = 1'b1;
      end
      if (gained_w) begin
         istat_nxt[`LDS_IRQ_LOCKED] = 1'b1;
      end
      if (valid_r) begin
         istat_nxt[`LDS_IRQ_RXWORD] = 1'b1;
      end
      irq_nxt = |(istat_nxt & imask_nxt);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= `LDS_CTRL_RST;
         istat_r <= '0;
         imask_r <= '0;
         for (int i = 0; i < LANES; i++) begin
            tx_word_r[i] <= `LDS_TX_RST;
         end
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         irq_r <= 1'b0;
         srcsync_r <= 1'b1;
      end else if (ce_i) begin
         ctrl_r <= ctrl_nxt;
         istat_r <= istat_nxt;
         imask_r <= imask_nxt;
         for (int i = 0; i < LANES; i++) begin
            tx_word_r[i] <= tx_word_nxt[i];
         end
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         irq_r <= irq_nxt;
         srcsync_r <= ctrl_nxt[`LDS_CTRL_SRCSYNC];
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign pll_areset_o = areset_r;
   assign pll_srcsync_o = srcsync_r;
   assign tx_ser_o = txp_w;
   assign fwd_clk_o = fwd_r;
   assign rx_par_o = par_r;
   assign rx_valid_o = valid_r;
   assign irq_o = irq_r;

endmodule // lds_top

//--- tb/lds_checker.sv
`timescale 1ns/10ps
// Port-level checks of the serdes block
module lds_checker #(
   parameter int LANES = 4,
   parameter int FACTOR = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Link
   input wire logic pll_areset_o,
   input wire logic [2*LANES-1:0] tx_ser_o,
   input wire logic [LANES*FACTOR-1:0] rx_par_o,
   input wire logic rx_valid_o
);
   logic [3:0] rel_cnt_r;
   logic [3:0] rel_cnt_nxt;

   // Saturating count of cycles since reset release
   always_comb begin
      rel_cnt_nxt = (rel_cnt_r == 4'hF) ? rel_cnt_r : rel_cnt_r + 4'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rel_cnt_r <= 4'h0;
      end else begin
         rel_cnt_r <= rel_cnt_nxt;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // -----------------------------------------------------------
   // Sequences
   // -----------------------------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   // PLL held in reset long enough for the lanes to have stopped
   sequence s_pll_held;
      pll_areset_o [*3];
   endsequence

   ack_answer_a: assert property (s_req |=> wb_ack_o)
      else $error("no ack after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   areset_hold_a: assert property (rel_cnt_r < 4'h9 |-> pll_areset_o)
      else $error("pll reset released early");
   word_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("word strobe too long");
   word_hold_a: assert property (!rx_valid_o |-> $stable(rx_par_o))
      else $error("rx word changed without strobe");
   tx_quiet_a: assert property (s_pll_held |-> tx_ser_o == '0)
      else $error("tx active while pll in reset");
   rx_quiet_a: assert property (s_pll_held ##1 pll_areset_o |-> !rx_valid_o)
      else $error("rx word while pll in reset");
endmodule // lds_checker

//--- tb/lds_far_model.sv
`timescale 1ns/10ps
// Far device: sends fixed lane words, rebuilds what the block launches
module lds_far_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // From the block
   input wire logic [7:0] tx_ser_i,
   input wire logic fwd_clk_i,
   // To the block and the bench
   output logic [7:0] rx_ser_o,
   output logic [31:0] tx_word_o
);
   logic [1:0] ph_r;
   logic [4:0] fwd_r;
   logic [7:0] hist_r [0:3];

   // Free word phase, four pairs per reference period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= ph_r + 2'h1;
      end
   end

   // Lane g carries word g+1, MSB pair first, edge-aligned
   always_comb begin
      logic [7:0] w;
      w = 8'h00;
      for (int g = 0; g < 4; g++) begin
         w = 8'(g + 1);
         rx_ser_o[2*g+:2] = w[7-2*ph_r-:2];
      end
   end

   // Rebuild each word from four pairs starting at the word-clock rise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fwd_r <= 5'h00;
         tx_word_o <= 32'h0000_0000;
         for (int i = 0; i < 4; i++) hist_r[i] <= 8'h00;
      end else begin
         fwd_r <= {fwd_r[3:0], fwd_clk_i};
         hist_r[0] <= tx_ser_i;
         for (int i = 1; i < 4; i++) hist_r[i] <= hist_r[i-1];
         if (fwd_r[3] && !fwd_r[4]) begin
            for (int g = 0; g < 4; g++) begin
               tx_word_o[8*g+:8] <= {hist_r[3][2*g+:2], hist_r[2][2*g+:2],
                  hist_r[1][2*g+:2], hist_r[0][2*g+:2]};
            end
         end
      end
   end
endmodule // lds_far_model

//--- tb/test_lvds_serdes_dual_edge_io_register_clocking.sv
`timescale 1ns/10ps
`include "lds_defs.svh"
// Bench for the serdes block facing its far device
module test_lvds_serdes_dual_edge_io_register_clocking;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic ce_i = 1'h1;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic pll_locked_i = 1'h0;
   logic spare_pll_output_i = 1'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic pll_areset_o;
   logic pll_srcsync_o;
   logic [7:0] rx_ser_i;
   logic [7:0] tx_ser_o;
   logic fwd_clk_o;
   logic [31:0] rx_par_o;
   logic rx_valid_o;
   logic irq_o;
   logic [31:0] tx_word;
   int num_errors = 0;
   int num_checks = 0;
   int cyc_cnt = 0;

   lds_top uut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_locked_i, .spare_pll_output_i,
      .pll_areset_o, .pll_srcsync_o, .rx_ser_i, .tx_ser_o, .fwd_clk_o, .rx_par_o,
      .rx_valid_o, .irq_o);
   lds_far_model far (.clk_i, .rst_i, .tx_ser_i(tx_ser_o), .fwd_clk_i(fwd_clk_o),
      .rx_ser_o(rx_ser_i), .tx_word_o(tx_word));

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   // Hang guard, far above the roughly 150 cycles the run needs
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         num_errors++;
         summarize();
      end
   end

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      chk("wb ack", 32'h1, 32'(wb_ack_o));
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] d;
      wb(1'h1, adr, wd, d);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb(1'h0, adr, 32'h0, d);
      chk(name, exp, d);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Bounded wait for a level, at least one edge
   task automatic wait_for(ref logic s, input logic v, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (s !== v && n < 100);
   endtask
   function automatic logic [7:0] rotl(input logic [7:0] w, input int n);
      return (w << n) | (w >> (8 - n));
   endfunction

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset();
      ticks(5);
      chk("areset held", 32'h1, 32'(pll_areset_o));
      chk("srcsync", 32'h1, 32'(pll_srcsync_o));
      ticks(8);
      chk("areset done", 32'h0, 32'(pll_areset_o));
      $display("t_reset done");
   endtask
   task automatic t_regs();
      rd_chk("ctrl", `LDS_OFS_CTRL, 32'h0000_000C);
      rd_chk("clkcfg", `LDS_OFS_CLKCFG, 32'h012C_5AE1);
      wr(`LDS_OFS_CLKCFG, 32'h0);
      rd_chk("clkcfg ro", `LDS_OFS_CLKCFG, 32'h012C_5AE1);
      rd_chk("unmapped", 8'h14, 32'h0);
      rd_chk("stat", `LDS_OFS_STAT, 32'h0);
      wr(`LDS_OFS_CTRL, 32'h04);
      chk("normal comp", 32'h0, 32'(pll_srcsync_o));
      wr(`LDS_OFS_CTRL, 32'h0C);
      $display("t_regs done");
   endtask
   task automatic t_irq();
      wr(`LDS_OFS_IMASK, 32'h0);
      pll_locked_i <= 1'h1;
      ticks(4);
      rd_chk("istat lock", `LDS_OFS_ISTAT, 32'h2);
      chk("irq masked", 32'h0, 32'(irq_o));
      wr(`LDS_OFS_IMASK, 32'h2);
      chk("irq set", 32'h1, 32'(irq_o));
      rd_chk("stat run", `LDS_OFS_STAT, 32'h3);
      wr(`LDS_OFS_ISTAT, 32'h2);
      chk("irq clr", 32'h0, 32'(irq_o));
      rd_chk("istat clr", `LDS_OFS_ISTAT, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_link();
      int n;
      int m;
      logic [31:0] d;
      logic [7:0] t0;
      for (int g = 0; g < 4; g++) wr(8'(`LDS_OFS_TX0 + 4 * g), 32'(g + 1));
      wr(`LDS_OFS_CTRL, 32'h0D);
      wait_for(rx_valid_o, 1'h1, n);
      wait_for(rx_valid_o, 1'h1, n);
      wait_for(rx_valid_o, 1'h1, n);
      chk("word spacing", 32'h4, 32'(n));
      d = rx_par_o;
      m = 0;
      for (int b = 0; b < 8; b++) if (d[b]) m = b;
      // Enable lands on a reference boundary here, so capture starts at bit 7
      chk("rx shift", 32'h2, 32'(m));
      for (int g = 0; g < 4; g++) chk("rx lane", 32'(rotl(8'(g + 1), m)), 32'(d[8*g+:8]));
      for (int g = 0; g < 4; g++) rd_chk("rx reg", 8'(`LDS_OFS_RX0 + 4 * g), 32'(rotl(8'(g + 1), m)));
      rd_chk("istat word", `LDS_OFS_ISTAT, 32'h4);
      for (int g = 0; g < 4; g++) chk("tx lane", 32'(rotl(8'(g + 1), 3)), 32'(tx_word[8*g+:8]));
      // Enable low freezes all state; frozen off a word strobe so it cannot stretch
      ticks(1);
      ce_i <= 1'h0;
      ticks(1);
      t0 = tx_ser_o;
      ticks(5);
      chk("ce tx hold", 32'(t0), 32'(tx_ser_o));
      chk("ce no word", 32'h0, 32'(rx_valid_o));
      ce_i <= 1'h1;
      wr(`LDS_OFS_CTRL, 32'h1D);
      spare_pll_output_i <= 1'h1;
      ticks(4);
      chk("spare hi", 32'h1, 32'(fwd_clk_o));
      spare_pll_output_i <= 1'h0;
      ticks(4);
      chk("spare lo", 32'h0, 32'(fwd_clk_o));
      wr(`LDS_OFS_CTRL, 32'h0D);
      $display("t_link done");
   endtask
   task automatic t_lost();
      int n;
      wr(`LDS_OFS_IMASK, 32'h1);
      pll_locked_i <= 1'h0;
      wait_for(pll_areset_o, 1'h1, n);
      chk("auto reset", 32'h1, 32'(pll_areset_o));
      ticks(2);
      chk("irq lost", 32'h1, 32'(irq_o));
      chk("tx quiet", 32'h0, 32'(tx_ser_o));
      wait_for(pll_areset_o, 1'h0, n);
      pll_locked_i <= 1'h1;
      ticks(4);
      rd_chk("relock", `LDS_OFS_STAT, 32'h3);
      $display("t_lost done");
   endtask

   // Main sequence, reset held three cycles
   initial begin
      ticks(3);
      rst_i <= 1'h0;
      t_reset();
      t_regs();
      t_irq();
      t_link();
      t_lost();
      summarize();
   end
endmodule // test_lvds_serdes_dual_edge_io_register_clocking

bind lds_top lds_checker #(.LANES(LANES), .FACTOR(FACTOR)) chk (.clk_i, .rst_i, .ce_i,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pll_areset_o, .tx_ser_o, .rx_par_o,
   .rx_valid_o);
